/* File: verilog/rif_regs.vh */
// Constants for the reset and external interrupt front end.
`ifndef RIF_REGS_VH
`define RIF_REGS_VH
// Machine cycles between reset release and the first fetch.
`define RIF_BOOT_WAIT_CYCLES  5'h10
// Program address that the first fetch uses.
`define RIF_RESET_VECTOR      16'h0000
// Field position of the boot-memory bit in the mode status register.
`define RIF_PROCESSOR_MODE_STATUS_REG_BOOT_BIT     0
// Reset value of the mode bit in the interrupt control register.
`define RIF_ICR_MODE_RESET    1'b0
// Source indices: flag and mask bit positions.
`define RIF_SRC_NMI           0
`define RIF_SRC_IRQ1          1
`define RIF_SRC_IRQ2          2
`define RIF_SRC_IRQ3          3
// Vector codes handed to the core, one per source.
`define RIF_VEC_NONE          3'h0
`define RIF_VEC_NMI           3'h1
`define RIF_VEC_IRQ1          3'h2
`define RIF_VEC_IRQ2          3'h3
`define RIF_VEC_IRQ3          3'h4
`endif

/* File: verilog/rif_front_end.v */
// Reset sequencer, boot-memory strap and external interrupt front end.
`timescale 1ns/10ps
`include "rif_regs.vh"

module rif_front_end (
  // Clock and reset.
  input  wire        core_clk,
  input  wire        resetn,
  // Device pins, all active low except the boot strap.
  input  wire        reset_input_pin_n,
  input  wire        boot_memory_select_pin,
  input  wire        nmi_pin_n,
  input  wire        hold_or_irq1_pin_n,
  input  wire        irq2_pin_n,
  input  wire        irq3_pin_n,
  // Core control: mask, disable, mode bit write and flag clear.
  input  wire        global_interrupt_disable,
  input  wire [3:0]  interrupt_mask_reg,
  input  wire        icr_mode_wr,
  input  wire        icr_mode_wdata,
  input  wire [3:0]  flag_clear,
  input  wire        irq_ack,
  // Core sequencing outputs.
  output reg         core_run,
  output reg         pc_load,
  output reg  [15:0] pc_load_addr,
  output reg         flash_select,
  output reg  [15:0] processor_mode_status_reg,
  output reg         interrupt_control_mode,
  output reg         hold_request,
  // Interrupt outputs.
  output reg  [3:0]  interrupt_flag_reg,
  output reg         irq_req,
  output reg  [2:0]  irq_vector
);

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************

  // Three stages per pin; stage 0 is read only by stage 1.
  reg  [4:0] sync0_reg;
  reg  [4:0] sync1_reg;
  reg  [4:0] sync2_reg;
  // Filtered level, updated only when stages 1 and 2 agree.
  reg  [4:0] level_reg;
  // Strap level, synchronised with the same depth.
  reg  [2:0] boot_sync_reg;
  // Raw pins: bit 0 reset, 1 nmi, 2 shared line, 3 irq2, 4 irq3.
  wire [4:0] pins_n;
  // Filter result that the level register takes at the next edge.
  wire [4:0] level_next;
  // High while the filtered reset pin is held low.
  wire       in_reset;
  // One-cycle strobes on a filtered high-to-low change.
  wire [3:0] fall;

  assign pins_n = {irq3_pin_n, irq2_pin_n, hold_or_irq1_pin_n,
                   nmi_pin_n, reset_input_pin_n};

  // A change counts once the second and third stages agree.
  assign level_next = (sync1_reg & sync2_reg) |
                      (level_reg & (sync1_reg | sync2_reg));

  // Synchroniser chain; pins idle high out of reset.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sync0_reg     <= 5'h1f;
      sync1_reg     <= 5'h1f;
      sync2_reg     <= 5'h1f;
      level_reg     <= 5'h1f;
      boot_sync_reg <= 3'h0;
    end else begin
      sync0_reg     <= pins_n;
      sync1_reg     <= sync0_reg;
      sync2_reg     <= sync1_reg;
      level_reg     <= level_next;
      boot_sync_reg <= {boot_sync_reg[1:0], boot_memory_select_pin};
    end
  end

  // Reset pin held low after filtering.
  assign in_reset = ~level_reg[0];
  // Falling edges of the four interrupt lines.
  assign fall = level_reg[4:1] & ~level_next[4:1];

  // ****************************************************************
  // Reset sequencer
  // ****************************************************************

  // Counts machine cycles after the reset pin goes high.
  // The count starts only once the filtered pin has risen, so the
  // first fetch comes a few cycles later than a bare count of sixteen
  // from the raw pin edge would give; the filter is worth that delay.
  reg [4:0] wait_reg;

  // The core idles while the pin is low, then waits sixteen cycles.
  // The program counter load is held high while the pin is low, then pulses once more as execution starts.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wait_reg     <= 5'h0;
      core_run     <= 1'b0;
      pc_load      <= 1'b0;
      pc_load_addr <= `RIF_RESET_VECTOR;
    end else if (in_reset) begin
      wait_reg     <= 5'h0;
      core_run     <= 1'b0;
      pc_load      <= 1'b1;
      pc_load_addr <= `RIF_RESET_VECTOR;
    end else if (!core_run) begin
      pc_load_addr <= `RIF_RESET_VECTOR;
      if (wait_reg == `RIF_BOOT_WAIT_CYCLES - 5'h1) begin
        core_run <= 1'b1;
        pc_load  <= 1'b1;
      end else begin
        wait_reg <= wait_reg + 5'h1;
        pc_load  <= 1'b0;
      end
    end else begin
      pc_load <= 1'b0;
    end
  end

  // ****************************************************************
  // Boot-memory strap and mode bits
  // ****************************************************************

  // The strap is caught while reset is held and frozen otherwise,
  // so a pin change during execution cannot remap program space.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      processor_mode_status_reg <= 16'h0000;
      flash_select              <= 1'b1;
      interrupt_control_mode    <= `RIF_ICR_MODE_RESET;
    end else begin
      // A strap that is still settling is not taken; the previous
      // value stands until the last two stages agree.
      if (in_reset &&
          (boot_sync_reg[2] == boot_sync_reg[1])) begin
        // Bit 0 holds the pin; low selects on-chip flash.
        processor_mode_status_reg[`RIF_PROCESSOR_MODE_STATUS_REG_BOOT_BIT] <=
          boot_sync_reg[2];
        flash_select <= ~boot_sync_reg[2];
      end
      if (in_reset) begin
        interrupt_control_mode <= `RIF_ICR_MODE_RESET;
      end else if (icr_mode_wr) begin
        interrupt_control_mode <= icr_mode_wdata;
      end
    end
  end

  // ****************************************************************
  // Pending flags and arbitration
  // ****************************************************************

  // Flag register next value, before the reset-pin override.
  wire [3:0] flag_next;
  // Pending sources that are allowed to request service.
  wire [3:0] enabled;

  // Hardware set beats a clear in the same cycle. The shared pin
  // always raises its flag, whatever the mode bit holds.
  assign flag_next = (interrupt_flag_reg & ~flag_clear) | fall;

  // Maskable sources need their mask bit and no global disable;
  // the non-maskable source bypasses both.
  assign enabled[`RIF_SRC_NMI] = interrupt_flag_reg[`RIF_SRC_NMI];
  assign enabled[3:1] = interrupt_flag_reg[3:1] &
                        interrupt_mask_reg[3:1] &
                        {3{~global_interrupt_disable}};

  // Flags, request and fixed-priority vector selection.
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_flag_reg <= 4'h0;
      irq_req            <= 1'b0;
      irq_vector         <= `RIF_VEC_NONE;
      hold_request       <= 1'b0;
    end else if (in_reset) begin
      interrupt_flag_reg <= 4'h0;
      irq_req            <= 1'b0;
      irq_vector         <= `RIF_VEC_NONE;
      hold_request       <= 1'b0;
    end else begin
      interrupt_flag_reg <= flag_next;
      // Hold request follows the shared line while mode is zero.
      // It uses the filtered level, not the edge, so it lasts as long
      // as the external master keeps the line low.
      hold_request <= ~interrupt_control_mode &
                      ~level_reg[`RIF_SRC_IRQ1 + 1];
      // The acknowledge drops the request for one cycle only; software
      // must clear the flag, or the request comes straight back.
      irq_req <= core_run & (|enabled) & ~irq_ack;
      // The vector is refreshed every cycle to name the top source.
      if (enabled[`RIF_SRC_NMI]) begin
        irq_vector <= `RIF_VEC_NMI;
      end else if (enabled[`RIF_SRC_IRQ1]) begin
        irq_vector <= `RIF_VEC_IRQ1;
      end else if (enabled[`RIF_SRC_IRQ2]) begin
        irq_vector <= `RIF_VEC_IRQ2;
      end else if (enabled[`RIF_SRC_IRQ3]) begin
        irq_vector <= `RIF_VEC_IRQ3;
      end else begin
        irq_vector <= `RIF_VEC_NONE;
      end
    end
  end

endmodule

/* File: test/rif_src_model.sv */
// Behavioural external reset circuit and interrupt sources.
`timescale 1ns/10ps
module rif_src_model (
  // Clock and requests from the bench.
  input  wire       core_clk,
  input  wire       rst_req,
  input  wire [3:0] fire,
  // Active-low pins, pulled up while idle.
  output reg        reset_input_pin_n,
  output reg  [3:0] irq_pins_n
);
  reg [3:0] low_cnt;  // Cycles left of the current low pulse.
  initial begin
    reset_input_pin_n = 1'b0;
    irq_pins_n = 4'hf;
    low_cnt = 4'h0;
  end
  // Ten-cycle pulses, long enough to pass the pin synchronizer and filter.
  always @(posedge core_clk) begin
    reset_input_pin_n <= !rst_req;
    if (fire != 4'h0) begin
      irq_pins_n <= ~fire;
      low_cnt <= 4'ha;
    end else if (low_cnt != 4'h0) begin
      low_cnt <= low_cnt - 4'h1;
      if (low_cnt == 4'h1)
        irq_pins_n <= 4'hf;
    end
  end
endmodule

/* File: test/rif_front_end_props.sv */
// Concurrent checks on the front end ports.
`timescale 1ns/10ps
module rif_front_end_props (
  input wire        core_clk,
  input wire        resetn,
  input wire        reset_input_pin_n,
  input wire [3:0]  interrupt_mask_reg,
  input wire        global_interrupt_disable,
  input wire        irq_ack,
  input wire        core_run,
  input wire        pc_load,
  input wire [15:0] pc_load_addr,
  input wire        flash_select,
  input wire [15:0] processor_mode_status_reg,
  input wire        interrupt_control_mode,
  input wire        hold_request,
  input wire [3:0]  interrupt_flag_reg,
  input wire        irq_req,
  input wire [2:0]  irq_vector
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_reset_halt: assert property (!reset_input_pin_n [*8] |->
    !core_run && pc_load && !interrupt_control_mode) else $error("run in reset");
  a_load_zero: assert property (pc_load |-> pc_load_addr == 16'h0000)
    else $error("load address not zero");
  a_start_pulse: assert property ($rose(core_run) |-> pc_load ##1 !pc_load)
    else $error("bad start pulse");
  a_map_select: assert property (
    flash_select == !processor_mode_status_reg[0]) else $error("bad map");
  a_strap_hold: assert property (core_run && $past(core_run) |->
    $stable(processor_mode_status_reg)) else $error("strap moved");
  a_nmi_vector: assert property (
    $rose(interrupt_flag_reg[0]) && core_run && !irq_ack |=>
    irq_req && irq_vector == 3'h1) else $error("nmi not taken");
  a_mask_gate: assert property (irq_req && irq_vector == 3'h3 |->
    $past(interrupt_mask_reg[2] && !global_interrupt_disable))
    else $error("masked irq2 taken");
  a_nmi_first: assert property (irq_req && irq_vector != 3'h1 |->
    !$past(interrupt_flag_reg[0])) else $error("nmi not first");
  a_hold_mode: assert property (
    hold_request |-> !$past(interrupt_control_mode))
    else $error("hold in interrupt mode");
endmodule
bind rif_front_end rif_front_end_props u_props (.*);

/* File: test/rif_front_end_tb.sv */
// Self-checking bench for the reset and interrupt front end.
`timescale 1ns/10ps
module rif_front_end_tb;
  reg core_clk, resetn, rst_req, boot_memory_select_pin, irq_ack;
  reg global_interrupt_disable, icr_mode_wr, icr_mode_wdata;
  reg  [3:0] interrupt_mask_reg, flag_clear, fire;
  wire reset_input_pin_n, nmi_pin_n, hold_or_irq1_pin_n, irq2_pin_n;
  wire irq3_pin_n, core_run, pc_load, flash_select, interrupt_control_mode;
  wire hold_request, irq_req;
  wire [15:0] pc_load_addr, processor_mode_status_reg;
  wire [3:0]  interrupt_flag_reg;
  wire [2:0]  irq_vector;
  integer     miscompares, num_checks, n;
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  rif_src_model src (.core_clk, .rst_req, .fire, .reset_input_pin_n,
    .irq_pins_n({irq3_pin_n, irq2_pin_n, hold_or_irq1_pin_n, nmi_pin_n}));
  rif_front_end uut (.*);
  task chk(input [31:0] got, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        miscompares = miscompares + 1;
        $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wt(input integer k);
    repeat (k) @(negedge core_clk);
  endtask
  // One-cycle request pulse, then time for the pin pulse to pass through.
  task pulse(input [3:0] f, input [3:0] c, input w);
    begin
      fire = f;
      flag_clear = c;
      icr_mode_wr = w;
      wt(1);
      fire = 4'h0;
      flag_clear = 4'h0;
      icr_mode_wr = 1'b0;
      wt(16);
    end
  endtask
  task do_reset(input s);
    begin
      rst_req = 1'b1;
      boot_memory_select_pin = s;
      wt(10);
      chk({core_run, pc_load, interrupt_control_mode}, 3'h2);
      chk({processor_mode_status_reg, flash_select}, {15'h0, s, !s});
      rst_req = 1'b0;
      n = 0;
      while (core_run !== 1'b1 && n < 40) begin
        wt(1);
        n = n + 1;
      end
      chk(n >= 16 && n <= 22, 1'b1);
      chk({pc_load, pc_load_addr, interrupt_flag_reg}, 21'h100000);
      $display("reset test done");
    end
  endtask
  task results;
    begin
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  initial begin
    #500000;
    miscompares = miscompares + 1;
    results;
  end
  initial begin
    {resetn, irq_ack, icr_mode_wr, fire, flag_clear} = 11'h0;
    {rst_req, icr_mode_wdata, global_interrupt_disable} = 3'h7;
    {boot_memory_select_pin, interrupt_mask_reg} = 5'h1f;
    {miscompares, num_checks} = 64'h0;
    wt(4);
    resetn = 1'b1;
    do_reset(1'b1);
    boot_memory_select_pin = 1'b0;
    wt(3);
    chk(processor_mode_status_reg, 16'h0001);
    do_reset(1'b0);
    pulse(4'h4, 4'h0, 1'b0);
    chk({irq_req, interrupt_flag_reg}, 5'h04);
    pulse(4'h1, 4'h0, 1'b0);
    chk({irq_req, irq_vector}, 4'h9);
    pulse(4'h8, 4'h1, 1'b0);
    chk({irq_req, interrupt_flag_reg}, 5'h0c);
    global_interrupt_disable = 1'b0;
    wt(3);
    chk({irq_req, irq_vector}, 4'hb);
    pulse(4'h0, 4'h4, 1'b0);
    chk({irq_req, irq_vector}, 4'hc);
    irq_ack = 1'b1;
    wt(1);
    irq_ack = 1'b0;
    chk(irq_req, 1'b0);
    interrupt_mask_reg = 4'h7;
    wt(3);
    chk(irq_req, 1'b0);
    pulse(4'h0, 4'h8, 1'b0);
    chk(interrupt_flag_reg, 4'h0);
    for (n = 0; n < 2; n = n + 1) begin
      fire = 4'h2;
      wt(1);
      fire = 4'h0;
      wt(6);
      chk(hold_request, n == 0);
      wt(10);
      chk({irq_req, irq_vector, interrupt_flag_reg}, 8'ha2);
      pulse(4'h0, 4'h2, 1'b1);
      chk(interrupt_control_mode, 1'b1);
    end
    pulse(4'h3, 4'h0, 1'b0);
    chk({irq_req, irq_vector, interrupt_flag_reg}, 8'h93);
    pulse(4'h0, 4'h1, 1'b0);
    chk({irq_req, irq_vector, interrupt_flag_reg}, 8'ha2);
    $display("interrupt test done");
    do_reset(1'b0);
    results;
  end
endmodule
